// ---- dv/tc_io_model.sv ----
`timescale 1ns/10ps
module tc_io_model (
  input  wire logic pclk,
  output logic      io_line_a,
  output logic      io_line_b,
  output logic      count_tick
);
  initial begin
    io_line_a  = 1'b0;
    io_line_b  = 1'b0;
    count_tick = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Levels stay put for several pclk so every edge survives the synchronisers
  task automatic set_line(input logic sel_b, input logic v);
    @(posedge pclk);
    if (sel_b) begin
      io_line_b <= v;
    end else begin
      io_line_a <= v;
    end
    hold(6);
  endtask
  // Counting clock rests low between ticks
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      count_tick <= 1'b1;
      hold(5);
      count_tick <= 1'b0;
      hold(5);
    end
  endtask
endmodule

// ---- dv/timer_channel_capture_mode_tb.sv ----
`timescale 1ns/10ps
module timer_channel_capture_mode_tb;
  localparam logic [7:0] CT = tc_capture_pkg::CTRL_OFF;
  localparam logic [7:0] MD = tc_capture_pkg::MODE_OFF;
  localparam logic [7:0] CN = tc_capture_pkg::COUNT_OFF;
  localparam logic [7:0] CA = tc_capture_pkg::CAPA_OFF;
  localparam logic [7:0] CB = tc_capture_pkg::CAPB_OFF;
  localparam logic [7:0] CC = tc_capture_pkg::CMPC_OFF;
  localparam logic [7:0] ST = tc_capture_pkg::STATUS_OFF;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        err_q;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sync_trigger;
  logic        count_tick;
  logic        io_a;
  logic        io_b;
  logic        a_out;
  logic        a_oe;
  logic        b_out;
  logic        b_oe;
  logic [31:0] rd_q;
  logic        rdy_q;
  logic [31:0] v;
  int          mismatches;
  int          compares;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  tc_capture tc_capture_inst (
    .pclk          (pclk),
    .presetn       (presetn),
    .ce            (ce),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .sync_trigger  (sync_trigger),
    .count_tick    (count_tick),
    .io_line_a_in  (io_a),
    .io_line_a_out (a_out),
    .io_line_a_oe  (a_oe),
    .io_line_b_in  (io_b),
    .io_line_b_out (b_out),
    .io_line_b_oe  (b_oe)
  );

  tc_io_model tc_io_model_inst (
    .pclk       (pclk),
    .io_line_a  (io_a),
    .io_line_b  (io_b),
    .count_tick (count_tick)
  );

  // Values as they stand just before each rising edge
  always @(negedge pclk) begin
    rd_q <= prdata;
    rdy_q <= pready;
    err_q <= pslverr;
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (rdy_q !== 1'b1) @(posedge pclk);
    r = rd_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp,
                       input logic [31:0] msk = 32'hFFFFFFFF);
    apb(1'b0, a, 32'h0, v);
    check(what, exp, v & msk);
  endtask

  function automatic logic [31:0] md(input logic [1:0] la, input logic [1:0] lb, input logic [1:0] te,
                                     input logic src, input logic [31:0] ex);
    return ex | ({30'h0, la} << tc_capture_pkg::MODE_LDA_LSB) | ({30'h0, lb} << tc_capture_pkg::MODE_LDB_LSB)
           | ({30'h0, te} << tc_capture_pkg::MODE_TEDGE_LSB) | ({31'h0, src} << tc_capture_pkg::MODE_TSRC_BIT);
  endfunction

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    close_out();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sync_trigger = 1'b0;
    ce = 1'b1;
    presetn = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("status", ST, 32'h0);
    rdchk("mode", MD, 32'h0);
    wr(8'h08, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h08, 32'h0);
    check("slverr", 32'h0, {31'h0, err_q});
    wr(CC, 32'h000000FF);
    rdchk("cmp_c", CC, 32'h000000FF);
    // A on rising, B on falling edge
    wr(MD, md(tc_capture_pkg::EDGE_RISE, tc_capture_pkg::EDGE_FALL, 2'h0, 1'b0, 32'h0));
    wr(CT, 32'h1);
    wr(CT, 32'h4);
    tc_io_model_inst.tick(1);
    rdchk("count", CN, 32'h0);
    tc_io_model_inst.tick(5);
    rdchk("count", CN, 32'h5);
    // Clock enable low freezes the counter and the pin synchronisers
    @(posedge pclk);
    ce <= 1'b0;
    tc_io_model_inst.tick(2);
    @(posedge pclk);
    ce <= 1'b1;
    rdchk("count_frozen", CN, 32'h5);
    tc_io_model_inst.set_line(1'b0, 1'b1);
    tc_io_model_inst.tick(3);
    tc_io_model_inst.set_line(1'b0, 1'b0);
    rdchk("status", ST, 32'h00010060);
    rdchk("status", ST, 32'h00010000);
    rdchk("cap_a", CA, 32'h5);
    rdchk("cap_b", CB, 32'h8);
    // Load order with A on falling, B on rising edge
    wr(MD, md(tc_capture_pkg::EDGE_FALL, tc_capture_pkg::EDGE_RISE, 2'h0, 1'b0, 32'h0));
    wr(CT, 32'h4);
    tc_io_model_inst.tick(4);
    tc_io_model_inst.set_line(1'b0, 1'b1);
    rdchk("status", ST, 32'h00030000);
    tc_io_model_inst.set_line(1'b0, 1'b0);
    tc_io_model_inst.tick(1);
    tc_io_model_inst.set_line(1'b0, 1'b1);
    tc_io_model_inst.tick(1);
    tc_io_model_inst.set_line(1'b0, 1'b0);
    rdchk("status", ST, 32'h00010062);
    rdchk("cap_a", CA, 32'h5);
    rdchk("cap_b", CB, 32'h4);
    // External trigger source and edge
    for (int s = 0; s < 2; s++) begin
      for (int e = 0; e < 4; e++) begin
        wr(MD, md(2'h0, 2'h0, e[1:0], s[0], 32'h0));
        apb(1'b0, ST, 32'h0, v);
        if (e == 3) begin
          tc_io_model_inst.set_line(~s[0], 1'b1);
          tc_io_model_inst.set_line(~s[0], 1'b0);
          rdchk("ext_other", ST, 32'h0, 32'h000000FF);
        end
        tc_io_model_inst.set_line(s[0], 1'b1);
        rdchk("ext_rise", ST, (e == 1 || e == 3) ? 32'h80 : 32'h0, 32'h000000FF);
        tc_io_model_inst.set_line(s[0], 1'b0);
        rdchk("ext_fall", ST, (e >= 2) ? 32'h80 : 32'h0, 32'h000000FF);
      end
    end
    // Sync trigger, compare-C restart
    wr(CC, 32'h2);
    wr(MD, md(2'h0, 2'h0, 2'h0, 1'b0, 32'h1 << tc_capture_pkg::MODE_CRST_BIT));
    apb(1'b0, ST, 32'h0, v);
    @(posedge pclk);
    sync_trigger <= 1'b1;
    @(posedge pclk);
    sync_trigger <= 1'b0;
    tc_io_model_inst.tick(4);
    rdchk("count", CN, 32'h0);
    tc_io_model_inst.tick(1);
    rdchk("count", CN, 32'h1);
    rdchk("status", ST, 32'h10, 32'h000000FF);
    // B load disables, then halts, the counter clock
    wr(CC, 32'h000000FF);
    for (int k = 0; k < 2; k++) begin
      wr(MD, md(tc_capture_pkg::EDGE_RISE, tc_capture_pkg::EDGE_FALL, 2'h0, 1'b0,
                32'h1 << (k == 1 ? tc_capture_pkg::MODE_CLKSTOP_BIT : tc_capture_pkg::MODE_CLKDIS_BIT)));
      wr(CT, 32'h1);
      wr(CT, 32'h4);
      apb(1'b0, ST, 32'h0, v);
      tc_io_model_inst.tick(3);
      tc_io_model_inst.set_line(1'b0, 1'b1);
      tc_io_model_inst.tick(1);
      tc_io_model_inst.set_line(1'b0, 1'b0);
      tc_io_model_inst.tick(2);
      rdchk("count", CN, 32'h3);
      rdchk("status", ST, (k == 1) ? 32'h00010060 : 32'h00000060);
      rdchk("cap_a", CA, 32'h2);
      rdchk("cap_b", CB, 32'h3);
    end
    check("oe_a", 32'h0, {31'h0, a_oe});
    check("oe_b", 32'h0, {31'h0, b_oe});
    check("out_a", 32'h0, {31'h0, a_out});
    check("out_b", 32'h0, {31'h0, b_out});
    close_out();
  end
endmodule

// ---- hdl/tc_capture.sv ----
`timescale 1ns/10ps
// How it works
// - Mode field waveform_select zero puts the channel into capture mode.
// - Qualifying io_line_a edge copies the counter into a capture register.
// - ra_load_edge and rb_load_edge pick the loading edge of each register.
// - capture_reg_a loads if unloaded since trigger or after a B load.
// - capture_reg_b loads only after an A load since trigger or last B.
// - Reload before read overwrites and sets load_overrun_flag.
// - External trigger offered beside sync, software and compare-C triggers.
// - trigger_source_select picks io_line_a or io_line_b for external trigger.
// - trigger_edge_select picks rising, falling or both edges.
// - trigger_edge_select zero disables the external trigger.
// - c_match_flag sets when counter equals compare_reg_c.
// - counter_overflow_flag sets when counter wraps past FFFF.
// - load_overrun_flag reports double load without read.
// - a_loaded_flag reports capture_reg_a loaded since the last status read.
// - b_loaded_flag reports capture_reg_b loaded since the last status read.
// - ext_trigger_flag reports a detected external trigger.
// - Flags set on events and clear when status is read.
// - A trigger zeroes the counter at the next valid count edge; a compare-C trigger zeroes it on the matching edge itself.
// - B load disables the counter clock when rb_load_clock_disable set.
// - B load halts the counter clock when rb_load_clock_halt set, if enabled.
// - c_match_restart raises a trigger on compare_reg_c equality.
module tc_capture (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sync_trigger,
  input  wire logic        count_tick,
  input  wire logic        io_line_a_in,
  output logic             io_line_a_out,
  output logic             io_line_a_oe,
  input  wire logic        io_line_b_in,
  output logic             io_line_b_out,
  output logic             io_line_b_oe
);
  tc_edge_if ea ();
  tc_edge_if eb ();
  tc_edge_if et ();

  tc_edge_sync u_sync_a (.pclk(pclk), .presetn(presetn), .ce(ce), .pin(io_line_a_in), .edg(ea));
  tc_edge_sync u_sync_b (.pclk(pclk), .presetn(presetn), .ce(ce), .pin(io_line_b_in), .edg(eb));
  tc_edge_sync u_sync_t (.pclk(pclk), .presetn(presetn), .ce(ce), .pin(count_tick), .edg(et));

  logic [31:0] channel_mode_reg;
  logic [15:0] counter;
  logic [15:0] capture_reg_a;
  logic [15:0] capture_reg_b;
  logic [15:0] compare_reg_c;
  logic        clk_enabled;
  logic        clk_running;
  logic        trig_pending;
  logic        a_done;
  logic        b_done;
  logic        a_unread;
  logic        b_unread;
  logic        counter_overflow_flag;
  logic        load_overrun_flag;
  logic        c_match_flag;
  logic        a_loaded_flag;
  logic        b_loaded_flag;
  logic        ext_trigger_flag;

  logic [31:0] next_channel_mode_reg;
  logic [15:0] next_counter;
  logic [15:0] next_capture_reg_a;
  logic [15:0] next_capture_reg_b;
  logic [15:0] next_compare_reg_c;
  logic        next_clk_enabled;
  logic        next_clk_running;
  logic        next_trig_pending;
  logic        next_a_done;
  logic        next_b_done;
  logic        next_a_unread;
  logic        next_b_unread;
  logic        next_counter_overflow_flag;
  logic        next_load_overrun_flag;
  logic        next_c_match_flag;
  logic        next_a_loaded_flag;
  logic        next_b_loaded_flag;
  logic        next_ext_trigger_flag;

  logic        wr;
  logic        rd;
  logic        capture_mode;
  logic [1:0]  ra_load_edge;
  logic [1:0]  rb_load_edge;
  logic [1:0]  trigger_edge_select;
  logic        trigger_source_select;
  logic        c_match_restart;
  logic        rb_load_clock_halt;
  logic        rb_load_clock_disable;
  logic        src_rise;
  logic        src_fall;
  logic        ext_trig;
  logic        c_match;
  logic        c_restart;
  logic        any_trig;
  logic        a_edge;
  logic        b_edge;
  logic        load_a;
  logic        load_b;
  logic        tick;
  logic        sr_read;
  logic        ra_read;
  logic        rb_read;

  // Bus decode: zero-wait APB
  assign wr      = psel & penable & pwrite & ce;
  assign rd      = psel & penable & ~pwrite & ce;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign sr_read = rd && paddr == tc_capture_pkg::STATUS_OFF;
  assign ra_read = rd && paddr == tc_capture_pkg::CAPA_OFF;
  assign rb_read = rd && paddr == tc_capture_pkg::CAPB_OFF;

  // Mode fields
  assign capture_mode          = ~channel_mode_reg[tc_capture_pkg::MODE_WAVE_BIT];
  assign ra_load_edge          = channel_mode_reg[tc_capture_pkg::MODE_LDA_LSB +: 2];
  assign rb_load_edge          = channel_mode_reg[tc_capture_pkg::MODE_LDB_LSB +: 2];
  assign trigger_edge_select   = channel_mode_reg[tc_capture_pkg::MODE_TEDGE_LSB +: 2];
  assign trigger_source_select = channel_mode_reg[tc_capture_pkg::MODE_TSRC_BIT];
  assign c_match_restart       = channel_mode_reg[tc_capture_pkg::MODE_CRST_BIT];
  assign rb_load_clock_halt    = channel_mode_reg[tc_capture_pkg::MODE_CLKSTOP_BIT];
  assign rb_load_clock_disable = channel_mode_reg[tc_capture_pkg::MODE_CLKDIS_BIT];

  // Pins never driven in capture mode
  assign io_line_a_out = 1'b0;
  assign io_line_a_oe  = 1'b0;
  assign io_line_b_out = 1'b0;
  assign io_line_b_oe  = 1'b0;

  // External trigger selection and edge
  assign src_rise = trigger_source_select ? eb.rise : ea.rise;
  assign src_fall = trigger_source_select ? eb.fall : ea.fall;

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      tc_capture_pkg::EDGE_NONE: hit = 1'b0;
      tc_capture_pkg::EDGE_RISE: hit = r;
      tc_capture_pkg::EDGE_FALL: hit = f;
      tc_capture_pkg::EDGE_BOTH: hit = r | f;
    endcase
    return hit;
  endfunction

  assign ext_trig = capture_mode & edge_hit(trigger_edge_select, src_rise, src_fall);
  assign tick     = ce & et.rise & clk_enabled & clk_running;
  assign c_match   = tick & ~trig_pending & (counter == compare_reg_c);
  assign c_restart = c_match & c_match_restart;
  assign any_trig  = sync_trigger | (wr && paddr == tc_capture_pkg::CTRL_OFF
                     && pwdata[tc_capture_pkg::CTRL_SWTRG_BIT]) | ext_trig | c_restart;

  assign a_edge = edge_hit(ra_load_edge, ea.rise, ea.fall);
  assign b_edge = edge_hit(rb_load_edge, ea.rise, ea.fall);
  assign load_a = capture_mode & a_edge & (~a_done | b_done);
  assign load_b = capture_mode & b_edge & a_done & ~b_done;

  always_comb begin
    next_channel_mode_reg      = channel_mode_reg;
    next_counter               = counter;
    next_capture_reg_a         = capture_reg_a;
    next_capture_reg_b         = capture_reg_b;
    next_compare_reg_c         = compare_reg_c;
    next_clk_enabled           = clk_enabled;
    next_clk_running           = clk_running;
    next_trig_pending          = trig_pending;
    next_a_done                = a_done;
    next_b_done                = b_done;
    next_a_unread              = a_unread & ~ra_read;
    next_b_unread              = b_unread & ~rb_read;
    next_counter_overflow_flag = counter_overflow_flag & ~sr_read;
    next_load_overrun_flag     = load_overrun_flag & ~sr_read;
    next_c_match_flag          = c_match_flag & ~sr_read;
    next_a_loaded_flag         = a_loaded_flag & ~sr_read;
    next_b_loaded_flag         = b_loaded_flag & ~sr_read;
    next_ext_trigger_flag      = ext_trigger_flag & ~sr_read;
    if (ce) begin
      if (wr) begin
        unique case (paddr)
          tc_capture_pkg::CTRL_OFF: begin
            if (pwdata[tc_capture_pkg::CTRL_CLKEN_BIT]) begin
              next_clk_enabled = 1'b1;
            end
            if (pwdata[tc_capture_pkg::CTRL_CLKDIS_BIT]) begin
              next_clk_enabled = 1'b0;
            end
          end
          tc_capture_pkg::MODE_OFF: next_channel_mode_reg = pwdata & tc_capture_pkg::MODE_MASK;
          tc_capture_pkg::CMPC_OFF: next_compare_reg_c = pwdata[15:0];
          default: ;
        endcase
      end
      // Counting and deferred trigger reset
      if (tick) begin
        if (trig_pending || c_restart) begin
          next_counter      = 16'h0000;
          next_trig_pending = 1'b0;
        end else begin
          next_counter = counter + 16'h0001;
          if (counter == tc_capture_pkg::COUNT_MAX) begin
            next_counter_overflow_flag = 1'b1;
          end
        end
      end
      if (c_match) begin
        next_c_match_flag = 1'b1;
      end
      if (any_trig) begin
        next_trig_pending = ~c_restart;
        next_a_done       = 1'b0;
        next_b_done       = 1'b0;
        if (next_clk_enabled) begin
          next_clk_running = 1'b1;
        end
      end
      if (ext_trig) begin
        next_ext_trigger_flag = 1'b1;
      end
      if (load_a) begin
        next_capture_reg_a = counter;
        next_a_done        = 1'b1;
        next_b_done        = 1'b0;
        next_a_unread      = 1'b1;
        next_a_loaded_flag = 1'b1;
        if (a_unread) begin
          next_load_overrun_flag = 1'b1;
        end
      end
      if (load_b) begin
        next_capture_reg_b = counter;
        next_b_done        = 1'b1;
        next_b_unread      = 1'b1;
        next_b_loaded_flag = 1'b1;
        if (b_unread) begin
          next_load_overrun_flag = 1'b1;
        end
        if (rb_load_clock_halt && clk_enabled) begin
          next_clk_running = 1'b0;
        end
        if (rb_load_clock_disable) begin
          next_clk_enabled = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_mode_reg      <= 32'h00000000;
      counter               <= 16'h0000;
      capture_reg_a         <= 16'h0000;
      capture_reg_b         <= 16'h0000;
      compare_reg_c         <= 16'h0000;
      clk_enabled           <= 1'b0;
      clk_running           <= 1'b0;
      trig_pending          <= 1'b0;
      a_done                <= 1'b0;
      b_done                <= 1'b0;
      a_unread              <= 1'b0;
      b_unread              <= 1'b0;
      counter_overflow_flag <= 1'b0;
      load_overrun_flag     <= 1'b0;
      c_match_flag          <= 1'b0;
      a_loaded_flag         <= 1'b0;
      b_loaded_flag         <= 1'b0;
      ext_trigger_flag      <= 1'b0;
    end else if (ce) begin
      channel_mode_reg      <= next_channel_mode_reg;
      counter               <= next_counter;
      capture_reg_a         <= next_capture_reg_a;
      capture_reg_b         <= next_capture_reg_b;
      compare_reg_c         <= next_compare_reg_c;
      clk_enabled           <= next_clk_enabled;
      clk_running           <= next_clk_running;
      trig_pending          <= next_trig_pending;
      a_done                <= next_a_done;
      b_done                <= next_b_done;
      a_unread              <= next_a_unread;
      b_unread              <= next_b_unread;
      counter_overflow_flag <= next_counter_overflow_flag;
      load_overrun_flag     <= next_load_overrun_flag;
      c_match_flag          <= next_c_match_flag;
      a_loaded_flag         <= next_a_loaded_flag;
      b_loaded_flag         <= next_b_loaded_flag;
      ext_trigger_flag      <= next_ext_trigger_flag;
    end
  end

  // Read data, combinational from registers
  always_comb begin
    prdata = 32'h00000000;
    if (psel && !pwrite) begin
      unique case (paddr)
        tc_capture_pkg::MODE_OFF:  prdata = channel_mode_reg;
        tc_capture_pkg::COUNT_OFF: prdata = {16'h0000, counter};
        tc_capture_pkg::CAPA_OFF:  prdata = {16'h0000, capture_reg_a};
        tc_capture_pkg::CAPB_OFF:  prdata = {16'h0000, capture_reg_b};
        tc_capture_pkg::CMPC_OFF:  prdata = {16'h0000, compare_reg_c};
        tc_capture_pkg::STATUS_OFF: begin
          prdata[tc_capture_pkg::ST_OVF_BIT]   = counter_overflow_flag;
          prdata[tc_capture_pkg::ST_LOVR_BIT]  = load_overrun_flag;
          prdata[tc_capture_pkg::ST_CMPC_BIT]  = c_match_flag;
          prdata[tc_capture_pkg::ST_LDA_BIT]   = a_loaded_flag;
          prdata[tc_capture_pkg::ST_LDB_BIT]   = b_loaded_flag;
          prdata[tc_capture_pkg::ST_ETRG_BIT]  = ext_trigger_flag;
          prdata[tc_capture_pkg::ST_CLKON_BIT] = clk_enabled;
          prdata[tc_capture_pkg::ST_IOA_BIT]   = ea.level;
          prdata[tc_capture_pkg::ST_IOB_BIT]   = eb.level;
        end
        default: prdata = 32'h00000000;
      endcase
    end
  end

  AST_SR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sr_read && !ext_trig |=> !ext_trigger_flag) else $error("ext flag not cleared");
  AST_EXT_SET: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ext_trig |=> ext_trigger_flag) else $error("ext flag missing");
  AST_NO_EXT: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_edge_select == tc_capture_pkg::EDGE_NONE |-> !ext_trig) else $error("ext trig while none");
  AST_LOAD_A: assert property (@(posedge pclk) disable iff (!presetn)
    ce && load_a |=> capture_reg_a == $past(counter) && a_loaded_flag) else $error("A load wrong");
  AST_B_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    load_b |-> a_done && !b_done) else $error("B loaded out of order");
  AST_OVR: assert property (@(posedge pclk) disable iff (!presetn)
    ce && load_a && a_unread |=> load_overrun_flag) else $error("overrun missed");
  AST_TRIG_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tick && trig_pending |=> counter == 16'h0000) else $error("counter not zeroed");
  AST_DIS: assert property (@(posedge pclk) disable iff (!presetn)
    ce && load_b && rb_load_clock_disable |=> !clk_enabled) else $error("clock not disabled");
  AST_PINS: assert property (@(posedge pclk) disable iff (!presetn)
    !io_line_a_oe && !io_line_b_oe) else $error("pin driven");
  AST_OVF: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tick && !trig_pending && !c_restart && counter == 16'hFFFF |=> counter_overflow_flag) else $error("ovf missed");
  AST_C_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    ce && c_restart |=> counter == 16'h0000) else $error("restart not zeroed");
  COV_LOAD_AB: cover property (@(posedge pclk) disable iff (!presetn) load_a ##[1:50] load_b);
  COV_OVR: cover property (@(posedge pclk) disable iff (!presetn) load_overrun_flag);
  COV_EXT: cover property (@(posedge pclk) disable iff (!presetn) ext_trig);
endmodule

// ---- hdl/tc_capture_pkg.sv ----
package tc_capture_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] MODE_OFF    = 8'h04;
  localparam logic [7:0] COUNT_OFF   = 8'h10;
  localparam logic [7:0] CAPA_OFF    = 8'h14;
  localparam logic [7:0] CAPB_OFF    = 8'h18;
  localparam logic [7:0] CMPC_OFF    = 8'h1C;
  localparam logic [7:0] STATUS_OFF  = 8'h20;
  localparam logic [7:0] EXTIN_OFF   = 8'h30;
  // Control register bits
  localparam int CTRL_CLKEN_BIT  = 0;
  localparam int CTRL_CLKDIS_BIT = 1;
  localparam int CTRL_SWTRG_BIT  = 2;
  // Mode register fields
  localparam int MODE_CLKSEL_LSB = 0;
  localparam int MODE_CLKSTOP_BIT = 6;
  localparam int MODE_CLKDIS_BIT  = 7;
  localparam int MODE_TEDGE_LSB   = 8;
  localparam int MODE_TSRC_BIT    = 10;
  localparam int MODE_CRST_BIT    = 14;
  localparam int MODE_WAVE_BIT    = 15;
  localparam int MODE_LDA_LSB     = 16;
  localparam int MODE_LDB_LSB     = 18;
  localparam logic [31:0] MODE_MASK = 32'h000FC7C7;
  // Status register bits
  localparam int ST_OVF_BIT  = 0;
  localparam int ST_LOVR_BIT = 1;
  localparam int ST_CMPC_BIT = 4;
  localparam int ST_LDA_BIT  = 5;
  localparam int ST_LDB_BIT  = 6;
  localparam int ST_ETRG_BIT = 7;
  localparam int ST_CLKON_BIT = 16;
  localparam int ST_IOA_BIT  = 17;
  localparam int ST_IOB_BIT  = 18;
  // Edge encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage

// ---- hdl/tc_edge_if.sv ----
`timescale 1ns/10ps
interface tc_edge_if;
  logic rise;
  logic fall;
  logic level;
  modport src (output rise, output fall, output level);
  modport dst (input rise, input fall, input level);
endinterface

// ---- hdl/tc_edge_sync.sv ----
`timescale 1ns/10ps
module tc_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic pin,
  tc_edge_if.src    edg
);
  logic [2:0] sh;
  logic [2:0] next_sh;
  // Two-stage synchroniser, third stage for edge detection
  always_comb begin
    next_sh = ce ? {sh[1:0], pin} : sh;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh <= 3'h0;
    end else begin
      sh <= next_sh;
    end
  end
  assign edg.level = sh[1];
  assign edg.rise  = sh[1] & ~sh[2];
  assign edg.fall  = ~sh[1] & sh[2];
endmodule
